// ==== logic/cfs_freq_rom.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: frequency selection table, registered read data
// Assumes: one read per clock
// Notes:   word is {cpu, mid group, pci, gear}
//////////////////////////////////////////////////////////////////////////////
module cfs_freq_rom
(
	// clock
	input  wire logic                       ref_clk,
	// lookup
	input  wire logic [cfs_pkg::CODE_W-1:0] addr,
	output logic      [cfs_pkg::ROM_W-1:0]  data
);
	logic [3*cfs_pkg::FREQ_W-1:0] row;

	// table kept in decimal for readability against the frequency list
	always_comb
	begin
		case (addr)
			5'h00: row = {16'd10090, 16'd6727, 16'd3363};
			5'h01: row = {16'd10000, 16'd6667, 16'd3333};
			5'h02: row = {16'd10300, 16'd6867, 16'd3433};
			5'h03: row = {16'd10500, 16'd7000, 16'd3500};
			5'h04: row = {16'd10700, 16'd7133, 16'd3567};
			5'h05: row = {16'd10900, 16'd7267, 16'd3633};
			5'h06: row = {16'd11100, 16'd7400, 16'd3700};
			5'h07: row = {16'd11400, 16'd7600, 16'd3800};
			5'h08: row = {16'd11700, 16'd7800, 16'd3900};
			5'h09: row = {16'd12000, 16'd8000, 16'd4000};
			5'h0A: row = {16'd12700, 16'd8467, 16'd4233};
			5'h0B: row = {16'd13000, 16'd8667, 16'd4333};
			5'h0C: row = {16'd13333, 16'd8889, 16'd4444};
			5'h0D: row = {16'd17000, 16'd5667, 16'd2833};
			5'h0E: row = {16'd18000, 16'd6000, 16'd3000};
			5'h0F: row = {16'd19000, 16'd6333, 16'd3167};
			5'h10: row = {16'd13390, 16'd6695, 16'd3348};
			5'h11: row = {16'd13333, 16'd6667, 16'd3333};
			5'h12: row = {16'd12000, 16'd6000, 16'd3000};
			5'h13: row = {16'd12500, 16'd6250, 16'd3125};
			5'h14: row = {16'd13490, 16'd6745, 16'd3373};
			5'h15: row = {16'd13700, 16'd6850, 16'd3425};
			5'h16: row = {16'd13900, 16'd6950, 16'd3475};
			5'h17: row = {16'd14100, 16'd7050, 16'd3525};
			5'h18: row = {16'd14300, 16'd7150, 16'd3575};
			5'h19: row = {16'd14500, 16'd7250, 16'd3625};
			5'h1A: row = {16'd15000, 16'd7500, 16'd3750};
			5'h1B: row = {16'd15500, 16'd7750, 16'd3875};
			5'h1C: row = {16'd16000, 16'd8000, 16'd4000};
			5'h1D: row = {16'd17000, 16'd8500, 16'd4250};
			5'h1E: row = {16'd6667, 16'd6667, 16'd3334};
			default: row = {16'd20000, 16'd6667, 16'd3333};
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		data <= {row, cfs_pkg::GEAR_CONST};
	end
endmodule : cfs_freq_rom

// ==== logic/cfs_freq_select.sv ====
//////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1 - control byte bit 7 enables direct divider programming, zero after reset
// RULE2 - when enabled, cpu frequency comes from 8-bit n and 7-bit m
// RULE3 - any write to the m field starts loading the new cpu frequency
// RULE4 - override clear: ratio follows the latched strap code
// RULE5 - override set: ratio follows the software select code
// RULE6 - factory test bits 1:0 reset to one; host writes ones there
// RULE7 - 32 codes map to fixed cpu, mid group, pci frequencies, one gear
// RULE8 - divider mode off: table entry of strap or select code drives outputs
// RULE9 - host should write n and m in one smbus transfer
// RULE10 - divider mode on: gear constant still from the selected code
// RULE11 - reserved bits read zero and ignore writes
//////////////////////////////////////////////////////////////////////////////
// Purpose: register bytes and frequency selection of the clock synthesizer
// Assumes: smbus engine gives byte strobes on smb_clk; straps are pins
// Notes:   selection outputs live on ref_clk, rd_data on smb_clk; settings cross by a toggle handshake
//////////////////////////////////////////////////////////////////////////////
module cfs_freq_select
(
	// reference clock domain
	input  wire logic                        ref_clk,
	input  wire logic                        rst_b,
	// smbus engine clock domain
	input  wire logic                        smb_clk,
	input  wire logic                        smb_rst_b,
	// byte register port (smb_clk)
	input  wire logic                        wr_en,
	input  wire logic [7:0]                  wr_index,
	input  wire logic [7:0]                  wr_data,
	input  wire logic                        rd_en,
	input  wire logic [7:0]                  rd_index,
	output logic      [7:0]                  rd_data,
	// power-on straps (asynchronous pins)
	input  wire logic [cfs_pkg::CODE_W-1:0]  strap_frequency_code,
	// frequency selection (ref_clk)
	output logic                             prog_mode_out,
	output logic      [7:0]                  cpu_divider_n_value,
	output logic      [6:0]                  cpu_divider_m_value,
	output logic                             freq_load_pulse,
	output logic      [cfs_pkg::CODE_W-1:0]  active_code,
	output logic      [cfs_pkg::FREQ_W-1:0]  cpu_freq,
	output logic      [cfs_pkg::FREQ_W-1:0]  mid_clock_group_freq,
	output logic      [cfs_pkg::FREQ_W-1:0]  pci_freq,
	output logic      [cfs_pkg::GEAR_W-1:0]  gear_constant
);
	//////////////////////////////////////////////////////////////////////////
	// smb_clk domain: register bytes
	logic [7:0] sel_ctrl_reg, sel_ctrl_next;
	logic [7:0] div_n_reg, div_n_next;
	logic [7:0] pfe_m_reg, pfe_m_next;
	logic [7:0] fact_test_reg, fact_test_next;
	logic       pending_reg, pending_next;
	logic       m_pend_reg, m_pend_next;
	logic [7:0] rd_data_next;
	logic       cfg_ready;
	logic       cfg_accept;
	logic       cfg_touch;
	logic [cfs_pkg::CODE_W-1:0] sw_sel_code;
	logic [cfs_pkg::CFG_W-1:0]  cfg_word;
	logic [cfs_pkg::CODE_W:0]   stat_s1_reg, stat_s2_reg;
	// strap latch lives on ref_clk, declared here because smb side reads it
	logic [cfs_pkg::CODE_W-1:0] strap_code_reg, strap_code_next;
	logic                       strap_latched_reg, strap_latched_next;

	always_comb
	begin
		sw_sel_code = {sel_ctrl_reg[cfs_pkg::SEL4_BIT],
			sel_ctrl_reg[cfs_pkg::SEL3_BIT],
			sel_ctrl_reg[cfs_pkg::SEL2_BIT],
			sel_ctrl_reg[cfs_pkg::SEL1_BIT],
			sel_ctrl_reg[cfs_pkg::SEL0_BIT]};
		cfg_word = {m_pend_reg, pfe_m_reg[cfs_pkg::PFE_BIT],
			pfe_m_reg[cfs_pkg::M_MSB:0], div_n_reg,
			sel_ctrl_reg[cfs_pkg::OVR_BIT], sw_sel_code};
		cfg_accept = pending_reg && cfg_ready;
	end

	always_comb
	begin
		sel_ctrl_next  = sel_ctrl_reg;
		div_n_next     = div_n_reg;
		pfe_m_next     = pfe_m_reg;
		fact_test_next = fact_test_reg;
		cfg_touch      = 1'b0;
		pending_next   = pending_reg && !cfg_accept;
		m_pend_next    = m_pend_reg && !cfg_accept;
		if (wr_en)
		begin
			case (wr_index)
				cfs_pkg::IDX_SEL_CTRL:
				begin
					// unused low bits stay zero
					sel_ctrl_next = wr_data & cfs_pkg::SEL_CTRL_MASK; // RULE11
					cfg_touch     = 1'b1;
				end
				cfs_pkg::IDX_DIV_N:
				begin
					div_n_next = wr_data; // RULE2
					cfg_touch  = 1'b1;
				end
				cfs_pkg::IDX_PFE_M:
				begin
					pfe_m_next  = wr_data; // RULE1
					m_pend_next = 1'b1; // RULE3
					cfg_touch   = 1'b1;
				end
				cfs_pkg::IDX_FACT_TEST:
					fact_test_next = wr_data & cfs_pkg::FACT_TEST_MASK; // RULE6
				default:
					fact_test_next = fact_test_reg; // RULE11
			endcase
		end
		// a write landing on the accept cycle is resent, set wins
		if (cfg_touch)
			pending_next = 1'b1;
	end

	always_comb
	begin
		rd_data_next = rd_data;
		if (rd_en)
		begin
			case (rd_index)
				cfs_pkg::IDX_SEL_CTRL:   rd_data_next = sel_ctrl_reg;
				cfs_pkg::IDX_DIV_N:      rd_data_next = div_n_reg;
				cfs_pkg::IDX_PFE_M:      rd_data_next = pfe_m_reg;
				cfs_pkg::IDX_FACT_TEST:  rd_data_next = fact_test_reg;
				cfs_pkg::IDX_STRAP_STAT:
					rd_data_next = {stat_s2_reg[cfs_pkg::CODE_W], 2'h0,
						stat_s2_reg[cfs_pkg::CODE_W-1:0]};
				default:                 rd_data_next = cfs_pkg::READ_ZERO; // RULE11
			endcase
		end
	end

	always_ff @(posedge smb_clk)
	begin
		if (!smb_rst_b)
		begin
			sel_ctrl_reg  <= cfs_pkg::SEL_CTRL_RESET;
			div_n_reg     <= cfs_pkg::DIV_N_RESET;
			pfe_m_reg     <= cfs_pkg::PFE_M_RESET; // RULE1
			fact_test_reg <= cfs_pkg::FACT_TEST_RESET; // RULE6
			pending_reg   <= 1'b1;
			m_pend_reg    <= 1'b0;
			rd_data       <= cfs_pkg::READ_ZERO;
			stat_s1_reg   <= '0;
			stat_s2_reg   <= '0;
		end
		else
		begin
			sel_ctrl_reg  <= sel_ctrl_next;
			div_n_reg     <= div_n_next;
			pfe_m_reg     <= pfe_m_next;
			fact_test_reg <= fact_test_next;
			pending_reg   <= pending_next;
			m_pend_reg    <= m_pend_next;
			rd_data       <= rd_data_next;
			// latched strap is static once captured, a bit sync is safe
			stat_s1_reg   <= {strap_latched_reg, strap_code_reg};
			stat_s2_reg   <= stat_s1_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// crossing: settings word from smb_clk to ref_clk
	logic                       cfg_valid;
	logic [cfs_pkg::CFG_W-1:0]  cfg_data;

	cfs_word_cross #(
		.W(cfs_pkg::CFG_W)
	) u_cross (
		.src_clk   (smb_clk),
		.src_rst_b (smb_rst_b),
		.src_valid (pending_reg),
		.src_data  (cfg_word),
		.src_ready (cfg_ready),
		.dst_clk   (ref_clk),
		.dst_rst_b (rst_b),
		.dst_valid (cfg_valid),
		.dst_data  (cfg_data)
	);

	//////////////////////////////////////////////////////////////////////////
	// ref_clk domain: strap latch and settings
	logic [cfs_pkg::CODE_W-1:0] strap_s1_reg, strap_s2_reg;
	logic [1:0]                 settle_reg, settle_next;
	logic                       pfe_reg, pfe_next;
	logic                       ovr_reg, ovr_next;
	logic [cfs_pkg::CODE_W-1:0] sel_reg, sel_next;
	logic [7:0]                 n_reg, n_next;
	logic [6:0]                 m_reg, m_next;
	logic                       load_next;
	logic [cfs_pkg::CODE_W-1:0] code_sel;

	always_comb
	begin
		settle_next        = settle_reg;
		strap_code_next    = strap_code_reg;
		strap_latched_next = strap_latched_reg;
		// straps captured once, a few cycles after reset release
		if (!strap_latched_reg)
		begin
			if (settle_reg == cfs_pkg::STRAP_SETTLE)
			begin
				strap_code_next    = strap_s2_reg;
				strap_latched_next = 1'b1;
			end
			else
				settle_next = settle_reg + cfs_pkg::CNT_STEP;
		end
		pfe_next  = pfe_reg;
		ovr_next  = ovr_reg;
		sel_next  = sel_reg;
		n_next    = n_reg;
		m_next    = m_reg;
		load_next = 1'b0;
		if (cfg_valid)
		begin
			{pfe_next, m_next, n_next, ovr_next, sel_next} =
				cfg_data[cfs_pkg::CFG_W-2:0];
			load_next = cfg_data[cfs_pkg::CFG_W-1]; // RULE3
		end
		// ratio and gear source, also in divider mode
		code_sel = ovr_reg ? sel_reg : strap_code_reg; // RULE4 RULE5 RULE10
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			strap_s1_reg      <= '0;
			strap_s2_reg      <= '0;
			strap_code_reg    <= '0;
			strap_latched_reg <= 1'b0;
			settle_reg        <= '0;
			pfe_reg           <= 1'b0;
			ovr_reg           <= 1'b0;
			sel_reg           <= '0;
			n_reg             <= '0;
			m_reg             <= '0;
			freq_load_pulse   <= 1'b0;
		end
		else
		begin
			strap_s1_reg      <= strap_frequency_code;
			strap_s2_reg      <= strap_s1_reg;
			strap_code_reg    <= strap_code_next;
			strap_latched_reg <= strap_latched_next;
			settle_reg        <= settle_next;
			pfe_reg           <= pfe_next;
			ovr_reg           <= ovr_next;
			sel_reg           <= sel_next;
			n_reg             <= n_next;
			m_reg             <= m_next;
			freq_load_pulse   <= load_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// table lookup and output registers
	logic [cfs_pkg::ROM_W-1:0]  rom_data;
	logic                       pfe_d_reg;
	logic [cfs_pkg::CODE_W-1:0] code_d_reg;

	cfs_freq_rom u_rom (
		.ref_clk (ref_clk),
		.addr    (code_sel),
		.data    (rom_data)
	); // RULE7

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			pfe_d_reg            <= 1'b0;
			code_d_reg           <= '0;
			prog_mode_out        <= 1'b0;
			cpu_divider_n_value  <= '0;
			cpu_divider_m_value  <= '0;
			active_code          <= '0;
			cpu_freq             <= '0;
			mid_clock_group_freq <= '0;
			pci_freq             <= '0;
			gear_constant        <= '0;
		end
		else
		begin
			// delay aligns mode and code with the registered table word
			pfe_d_reg            <= pfe_reg;
			code_d_reg           <= code_sel;
			prog_mode_out        <= pfe_d_reg; // RULE1 RULE8
			cpu_divider_n_value  <= n_reg; // RULE2
			cpu_divider_m_value  <= m_reg; // RULE2
			active_code          <= code_d_reg;
			{cpu_freq, mid_clock_group_freq, pci_freq, gear_constant} <=
				rom_data; // RULE8 RULE10
		end
	end
endmodule : cfs_freq_select

// ==== logic/cfs_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants of the frequency-selection block
// Assumes: byte registers addressed by an 8-bit index from the smbus engine
// Notes:   frequencies are in units of 10 kHz, gear constant in 1e-5 units
//////////////////////////////////////////////////////////////////////////////
package cfs_pkg;
	// register indices
	localparam logic [7:0] IDX_SEL_CTRL   = 8'h00;
	localparam logic [7:0] IDX_DIV_N      = 8'h0D;
	localparam logic [7:0] IDX_PFE_M      = 8'h0E;
	localparam logic [7:0] IDX_FACT_TEST  = 8'h0F;
	localparam logic [7:0] IDX_RSVD_A     = 8'h10;
	localparam logic [7:0] IDX_RSVD_B     = 8'h11;
	localparam logic [7:0] IDX_STRAP_STAT = 8'h12;
	// field positions
	localparam int PFE_BIT   = 7;
	localparam int M_MSB     = 6;
	localparam int OVR_BIT   = 3;
	localparam int SEL4_BIT  = 2;
	localparam int SEL3_BIT  = 7;
	localparam int SEL2_BIT  = 6;
	localparam int SEL1_BIT  = 5;
	localparam int SEL0_BIT  = 4;
	localparam int STAT_LATCHED_BIT = 7;
	// reset values and masks
	localparam logic [7:0] SEL_CTRL_RESET  = 8'h00;
	localparam logic [7:0] SEL_CTRL_MASK   = 8'hFC;
	localparam logic [7:0] DIV_N_RESET     = 8'h00;
	localparam logic [7:0] PFE_M_RESET     = 8'h00;
	localparam logic [7:0] FACT_TEST_RESET = 8'h03;
	localparam logic [7:0] FACT_TEST_MASK  = 8'h03;
	localparam logic [7:0] READ_ZERO       = 8'h00;
	// widths
	localparam int CODE_W = 5;
	localparam int FREQ_W = 16;
	localparam int GEAR_W = 23;
	localparam int CFG_W  = 23;
	localparam int ROM_W  = 3 * FREQ_W + GEAR_W;
	// gear constant 48.00741 in units of 1e-5
	localparam logic [GEAR_W-1:0] GEAR_CONST = 23'h4940E5;
	// strap settle: cycles after reset release before the strap latch
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [1:0] CNT_STEP     = 2'h1;
endpackage : cfs_pkg

// ==== logic/cfs_word_cross.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: toggle handshake carrying one word between two clock domains
// Assumes: source holds nothing itself; word is captured on accept
// Notes:   one word in flight; src_ready low until the ack returns
//////////////////////////////////////////////////////////////////////////////
module cfs_word_cross #(
	parameter int W = 8
)
(
	// source side
	input  wire logic         src_clk,
	input  wire logic         src_rst_b,
	input  wire logic         src_valid,
	input  wire logic [W-1:0] src_data,
	output logic              src_ready,
	// destination side
	input  wire logic         dst_clk,
	input  wire logic         dst_rst_b,
	output logic              dst_valid,
	output logic      [W-1:0] dst_data
);
	logic         req_reg, req_next, ack_s1_reg, ack_s2_reg;
	logic [W-1:0] hold_reg, hold_next;
	logic         req_s1_reg, req_s2_reg, seen_reg, seen_next;
	logic         dv_next;
	logic [W-1:0] dd_next;

	always_comb
	begin
		src_ready = (req_reg == ack_s2_reg);
		req_next  = req_reg;
		hold_next = hold_reg;
		if (src_valid && src_ready)
		begin
			req_next  = ~req_reg;
			hold_next = src_data;
		end
	end

	always_ff @(posedge src_clk)
	begin
		if (!src_rst_b)
		begin
			req_reg    <= 1'b0;
			hold_reg   <= '0;
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
		end
		else
		begin
			req_reg    <= req_next;
			hold_reg   <= hold_next;
			ack_s1_reg <= seen_reg;
			ack_s2_reg <= ack_s1_reg;
		end
	end

	// hold_reg is stable while the request toggle crosses
	always_comb
	begin
		seen_next = req_s2_reg;
		dv_next   = (req_s2_reg != seen_reg);
		dd_next   = dv_next ? hold_reg : dst_data;
	end

	always_ff @(posedge dst_clk)
	begin
		if (!dst_rst_b)
		begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			seen_reg   <= 1'b0;
			dst_valid  <= 1'b0;
			dst_data   <= '0;
		end
		else
		begin
			req_s1_reg <= req_reg;
			req_s2_reg <= req_s1_reg;
			seen_reg   <= seen_next;
			dst_valid  <= dv_next;
			dst_data   <= dd_next;
		end
	end
endmodule : cfs_word_cross

// ==== testbench/cfs_freq_select_checker.sv ====
// Purpose: concurrent checks on the frequency-selection ports
// Assumes: both resets synchronous, active low
// Notes:   table frequencies in 10 kHz units
////////////////////////////////////////
module cfs_freq_select_checker
(
	// clocks and resets
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        smb_clk,
	input wire logic        smb_rst_b,
	// register read port
	input wire logic        rd_en,
	input wire logic [7:0]  rd_index,
	input wire logic [7:0]  rd_data,
	// selection outputs
	input wire logic        prog_mode_out,
	input wire logic [6:0]  cpu_divider_m_value,
	input wire logic        freq_load_pulse,
	input wire logic [4:0]  active_code,
	input wire logic [15:0] cpu_freq,
	input wire logic [15:0] mid_clock_group_freq,
	input wire logic [15:0] pci_freq,
	input wire logic [22:0] gear_constant
);
	timeunit 1ns;
	timeprecision 1ps;
	a_rsvd_read_zero: assert property (@(posedge smb_clk)
		disable iff (!smb_rst_b) rd_en && (rd_index == cfs_pkg::IDX_RSVD_A
		|| rd_index == cfs_pkg::IDX_RSVD_B) |=> rd_data == 8'h00)
		else $error("reserved byte read nonzero");
	a_ctrl_low_zero: assert property (@(posedge smb_clk)
		disable iff (!smb_rst_b) rd_en && rd_index == cfs_pkg::IDX_SEL_CTRL
		|=> rd_data[1:0] == 2'h0)
		else $error("select byte low bits nonzero");
	a_test_high_zero: assert property (@(posedge smb_clk)
		disable iff (!smb_rst_b) rd_en && rd_index == cfs_pkg::IDX_FACT_TEST
		|=> rd_data[7:2] == 6'h00)
		else $error("test byte upper bits nonzero");
	a_gear_fixed: assert property (@(posedge ref_clk)
		disable iff (!rst_b) gear_constant != 23'h0
		|-> gear_constant == 23'h4940E5)
		else $error("gear constant wrong");
	a_load_single: assert property (@(posedge ref_clk)
		disable iff (!rst_b) freq_load_pulse |=> !freq_load_pulse)
		else $error("load pulse longer than one cycle");
	a_m_with_load: assert property (@(posedge ref_clk)
		disable iff (!rst_b) $changed(cpu_divider_m_value) |-> freq_load_pulse
		|| $past(freq_load_pulse) || $past(freq_load_pulse, 2)
		|| $past(freq_load_pulse, 3))
		else $error("m changed without load pulse");
	a_mode_with_load: assert property (@(posedge ref_clk)
		disable iff (!rst_b) $rose(prog_mode_out) |-> freq_load_pulse
		|| $past(freq_load_pulse) || $past(freq_load_pulse, 2)
		|| $past(freq_load_pulse, 3))
		else $error("divider mode set without load");
	a_table_code01: assert property (@(posedge ref_clk)
		disable iff (!rst_b) (active_code == 5'h01) [*4] |-> cpu_freq == 16'h2710
		&& mid_clock_group_freq == 16'h1A0B && pci_freq == 16'h0D05)
		else $error("table entry 01 wrong");
	a_table_code1f: assert property (@(posedge ref_clk)
		disable iff (!rst_b) (active_code == 5'h1F) [*4] |-> cpu_freq == 16'h4E20
		&& mid_clock_group_freq == 16'h1A0B && pci_freq == 16'h0D05)
		else $error("table entry 1f wrong");
endmodule : cfs_freq_select_checker

bind cfs_freq_select cfs_freq_select_checker u_chk (.ref_clk(ref_clk),
	.rst_b(rst_b), .smb_clk(smb_clk), .smb_rst_b(smb_rst_b), .rd_en(rd_en),
	.rd_index(rd_index), .rd_data(rd_data), .prog_mode_out(prog_mode_out),
	.cpu_divider_m_value(cpu_divider_m_value),
	.freq_load_pulse(freq_load_pulse), .active_code(active_code),
	.cpu_freq(cpu_freq), .mid_clock_group_freq(mid_clock_group_freq),
	.pci_freq(pci_freq), .gear_constant(gear_constant));

// ==== testbench/cfs_host_model.sv ====
// Purpose: management host driving the byte register port
// Assumes: one byte per smb_clk cycle while wr_en is high
// Notes:   released lines show inverted data so stale values never pass
////////////////////////////////////////
module cfs_host_model
(
	// clock and reset
	input wire logic       smb_clk,
	input wire logic       smb_rst_b,
	// byte register port
	output logic           wr_en,
	output logic     [7:0] wr_index,
	output logic     [7:0] wr_data,
	output logic           rd_en,
	output logic     [7:0] rd_index,
	input wire logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		wr_en = 1'b0;
		wr_index = 8'h00;
		wr_data = 8'h00;
		rd_en = 1'b0;
		rd_index = 8'h00;
	end

	task automatic write_byte(input logic [7:0] idx, input logic [7:0] dat);
		@(posedge smb_clk);
		wr_en <= 1'b1;
		wr_index <= idx;
		// test bits are always written as ones
		wr_data <= (idx == cfs_pkg::IDX_FACT_TEST) ? (dat | 8'h03) : dat;
		@(posedge smb_clk);
		wr_en <= 1'b0;
		wr_index <= ~idx;
		wr_data <= ~dat;
	endtask : write_byte

	// n then m in one burst so no half-programmed value is loaded
	task automatic write_n_m(input logic [7:0] n, input logic [7:0] pm);
		@(posedge smb_clk);
		wr_en <= 1'b1;
		wr_index <= cfs_pkg::IDX_DIV_N;
		wr_data <= n;
		@(posedge smb_clk);
		wr_index <= cfs_pkg::IDX_PFE_M;
		wr_data <= pm;
		@(posedge smb_clk);
		wr_en <= 1'b0;
		wr_index <= 8'hFF;
		wr_data <= ~pm;
	endtask : write_n_m

	task automatic read_byte(input logic [7:0] idx, output logic [7:0] dat);
		@(posedge smb_clk);
		rd_en <= 1'b1;
		rd_index <= idx;
		@(posedge smb_clk);
		rd_en <= 1'b0;
		rd_index <= ~idx;
		@(posedge smb_clk);
		#1;
		dat = rd_data;
	endtask : read_byte
endmodule : cfs_host_model

// ==== testbench/tb_cfs_freq_select.sv ====
// Purpose: register sequences checked against the selection outputs
// Assumes: strap pins held at code 01 for the first power-on, 0D for the second
// Notes:   waits on outputs are bounded; timeout ends the run
////////////////////////////////////////
module tb_cfs_freq_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        smb_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        smb_rst_b = 1'b0;
	logic        wr_en, rd_en, prog_mode_out, freq_load_pulse;
	logic [7:0]  wr_index, wr_data, rd_index, rd_data, cpu_divider_n_value;
	logic [6:0]  cpu_divider_m_value;
	logic [4:0]  strap = 5'h01;
	logic [4:0]  active_code;
	logic [15:0] cpu_freq, mid_clock_group_freq, pci_freq;
	logic [22:0] gear_constant;
	int          n_mismatch = 0;
	int          checks = 0;
	int          cycles = 0;
	logic [7:0]  ri[7] = '{8'h0E, 8'h0F, 8'h0D, 8'h00, 8'h10, 8'h11, 8'h55};
	logic [7:0]  re[7] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  sb[4] = '{8'h03, 8'h0B, 8'hDB, 8'hFF};
	logic [4:0]  sc[4] = '{5'h01, 5'h00, 5'h0D, 5'h1F};
	logic [15:0] tc[4] = '{16'h2710, 16'h276A, 16'h4268, 16'h4E20};
	logic [15:0] tm[4] = '{16'h1A0B, 16'h1A47, 16'h1623, 16'h1A0B};
	logic [15:0] tp[4] = '{16'h0D05, 16'h0D23, 16'h0B11, 16'h0D05};

	always #10 ref_clk = ~ref_clk;
	// offset start keeps the two clocks out of step
	always
	begin
		if ($time == 0)
			#7;
		#16 smb_clk = ~smb_clk;
	end

	cfs_host_model u_host (.smb_clk(smb_clk), .smb_rst_b(smb_rst_b),
		.wr_en(wr_en), .wr_index(wr_index), .wr_data(wr_data), .rd_en(rd_en),
		.rd_index(rd_index), .rd_data(rd_data));
	cfs_freq_select u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .smb_clk(smb_clk),
		.smb_rst_b(smb_rst_b), .wr_en(wr_en), .wr_index(wr_index),
		.wr_data(wr_data), .rd_en(rd_en), .rd_index(rd_index),
		.rd_data(rd_data), .strap_frequency_code(strap),
		.prog_mode_out(prog_mode_out), .cpu_divider_n_value(cpu_divider_n_value),
		.cpu_divider_m_value(cpu_divider_m_value),
		.freq_load_pulse(freq_load_pulse), .active_code(active_code),
		.cpu_freq(cpu_freq), .mid_clock_group_freq(mid_clock_group_freq),
		.pci_freq(pci_freq), .gear_constant(gear_constant));

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: byte %h not %h", $time, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_out(input logic [22:0] got, input logic [22:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: output %h not %h", $time, got, exp);
		end
	endtask : cmp_out

	task automatic check_table(input logic [4:0] code, input logic [15:0] cpu,
		input logic [15:0] mid, input logic [15:0] pci);
		int k;
		k = 0;
		while (active_code !== code && k < 80)
		begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		repeat (3) @(posedge ref_clk);
		#1;
		cmp_out({18'h0, active_code}, {18'h0, code});
		cmp_out({7'h00, cpu_freq}, {7'h00, cpu});
		cmp_out({7'h00, mid_clock_group_freq}, {7'h00, mid});
		cmp_out({7'h00, pci_freq}, {7'h00, pci});
		cmp_out(gear_constant, cfs_pkg::GEAR_CONST);
	endtask : check_table

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial
	begin
		logic [7:0]  rv;
		logic        seen;
		int          k;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge smb_clk);
		smb_rst_b <= 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			u_host.read_byte(ri[i], rv);
			cmp_reg(rv, re[i]);
		end
		check_table(5'h01, 16'h2710, 16'h1A0B, 16'h0D05);
		cmp_out({22'h0, prog_mode_out}, 23'h0);
		u_host.read_byte(cfs_pkg::IDX_STRAP_STAT, rv);
		cmp_reg(rv, 8'h81);
		$display("test reset values done");
		u_host.write_byte(cfs_pkg::IDX_FACT_TEST, 8'hFC);
		u_host.read_byte(cfs_pkg::IDX_FACT_TEST, rv);
		cmp_reg(rv, 8'h03);
		u_host.write_byte(cfs_pkg::IDX_RSVD_A, 8'hFF);
		u_host.read_byte(cfs_pkg::IDX_RSVD_A, rv);
		cmp_reg(rv, 8'h00);
		$display("test reserved bytes done");
		for (int i = 0; i < 4; i++)
		begin
			u_host.write_byte(cfs_pkg::IDX_SEL_CTRL, sb[i]);
			u_host.read_byte(cfs_pkg::IDX_SEL_CTRL, rv);
			cmp_reg(rv, sb[i] & 8'hFC);
			check_table(sc[i], tc[i], tm[i], tp[i]);
		end
		$display("test code selection done");
		u_host.write_n_m(8'h5A, 8'h85);
		k = 0;
		seen = 1'b0;
		while (!seen && k < 80)
		begin
			@(posedge ref_clk);
			#1;
			seen = (freq_load_pulse === 1'b1);
			k++;
		end
		cmp_out({22'h0, seen}, 23'h1);
		repeat (4) @(posedge ref_clk);
		#1;
		cmp_out({22'h0, prog_mode_out}, 23'h1);
		cmp_out({16'h0, cpu_divider_m_value}, 23'h5);
		cmp_out({15'h0, cpu_divider_n_value}, 23'h5A);
		check_table(5'h1F, 16'h4E20, 16'h1A0B, 16'h0D05);
		u_host.read_byte(cfs_pkg::IDX_PFE_M, rv);
		cmp_reg(rv, 8'h85);
		u_host.write_byte(cfs_pkg::IDX_SEL_CTRL, 8'h00);
		check_table(5'h01, 16'h2710, 16'h1A0B, 16'h0D05);
		cmp_out({22'h0, prog_mode_out}, 23'h1);
		$display("test divider mode done");
		// second power-on with other straps: latch must follow the pins
		@(posedge ref_clk);
		strap <= 5'h0D;
		rst_b <= 1'b0;
		@(posedge smb_clk);
		smb_rst_b <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge smb_clk);
		smb_rst_b <= 1'b1;
		check_table(5'h0D, 16'h4268, 16'h1623, 16'h0B11);
		cmp_out({22'h0, prog_mode_out}, 23'h0);
		u_host.read_byte(cfs_pkg::IDX_STRAP_STAT, rv);
		cmp_reg(rv, 8'h8D);
		u_host.read_byte(cfs_pkg::IDX_PFE_M, rv);
		cmp_reg(rv, 8'h00);
		$display("test strap after reset done");
		wrap_up();
	end
endmodule : tb_cfs_freq_select
